// ### core/fmcr_defines.svh
// offsets, field positions and reset values of the flash mode control block
`ifndef FMCR_DEFINES_SVH
`define FMCR_DEFINES_SVH

`define FMCR_CTRL_OFFSET      12'h000
`define FMCR_OBS_OFFSET       12'h004

`define FMCR_BIT_HW_PERMIT    7
`define FMCR_BIT_SW_PERMIT    6
`define FMCR_BIT_ERASE_SETUP  5
`define FMCR_BIT_PROG_SETUP   4
`define FMCR_BIT_ERASE_CHECK  3
`define FMCR_BIT_PROG_CHECK   2
`define FMCR_BIT_ERASE        1
`define FMCR_BIT_PROG         0

`define FMCR_RESET_HW_HIGH    8'h80
`define FMCR_RESET_HW_LOW     8'h00
`define FMCR_WRITABLE_MASK    8'h7f

`endif

// ### core/fmcr_pkg.sv
// types shared by the flash mode control block
package fmcr_pkg;

   typedef enum logic [2:0] {
      FMCR_MODE_READ        = 3'h0,
      FMCR_MODE_PROG_CHECK  = 3'h1,
      FMCR_MODE_ERASE_CHECK = 3'h2,
      FMCR_MODE_PROG_SETUP  = 3'h3,
      FMCR_MODE_PROG        = 3'h4,
      FMCR_MODE_ERASE_SETUP = 3'h5,
      FMCR_MODE_ERASE       = 3'h6,
      FMCR_MODE_PERMIT      = 3'h7
   } fmcr_mode_t;

endpackage

// ### core/fmcr_write_gate.sv
// per-bit write permission for the mode control register
`include "fmcr_defines.svh"

module fmcr_write_gate #(
   parameter int WIDTH = 8
) (
   input  wire logic [WIDTH-1:0] i_cur,
   input  wire logic [WIDTH-1:0] i_wdata,
   input  wire logic             i_hw_permit,
   output logic      [WIDTH-1:0] o_next
);

   initial begin
      if (WIDTH != 8) begin
         $error("fmcr_write_gate: WIDTH must be 8");
      end
   end

   logic [WIDTH-1:0] allow;

   always_comb begin
      allow = '0;
      allow[`FMCR_BIT_SW_PERMIT]   = i_hw_permit;
      allow[`FMCR_BIT_ERASE_SETUP] = i_hw_permit
                                     & i_cur[`FMCR_BIT_SW_PERMIT];
      allow[`FMCR_BIT_PROG_SETUP]  = i_hw_permit
                                     & i_cur[`FMCR_BIT_SW_PERMIT];
      allow[`FMCR_BIT_ERASE_CHECK] = i_hw_permit
                                     & i_cur[`FMCR_BIT_SW_PERMIT];
      allow[`FMCR_BIT_PROG_CHECK]  = i_hw_permit
                                     & i_cur[`FMCR_BIT_SW_PERMIT];
      allow[`FMCR_BIT_ERASE]       = i_hw_permit
                                     & i_cur[`FMCR_BIT_SW_PERMIT]
                                     & i_cur[`FMCR_BIT_ERASE_SETUP];
      allow[`FMCR_BIT_PROG]        = i_hw_permit
                                     & i_cur[`FMCR_BIT_SW_PERMIT]
                                     & i_cur[`FMCR_BIT_PROG_SETUP];
   end

   // bit 7 is never stored; it mirrors the pin
   assign o_next = (i_wdata & allow) | (i_cur & ~allow
                   & `FMCR_WRITABLE_MASK);

endmodule // fmcr_write_gate

// ### core/fmcr_top.sv
// flash mode control register with apb slave
`include "fmcr_defines.svh"

// Notes on behaviour
// - eight-bit register: hw permit, sw permit, setups, checks, erase, program.
// - bit 7 is read-only and mirrors the hardware permit pin.
// - reset or standby gives 80 with pin high, 00 with low.
// - sw permit write taken only while hw permit reads 1.
// - setup and check bits written only with both permits at 1.
// - erase bit written only with both permits and erase setup.
// - program bit written only with both permits and program setup.
// - check modes entered by sw permit first, then a check bit.
// - program entered by permit, program setup, then program bit.
// - erase entered by permit, erase setup, then erase bit.
// - flash disabled: register reads 00 and writes are dropped.
// - check, erase and program bits select a mode; program wins, then erase, program check, erase check.
// - sw permit enables program and erase; needs hw permit.
module fmcr_top #(
   parameter int ADDR_W = 12
) (
   input  wire logic              i_ref_clk,
   input  wire logic              i_rst_b,
   input  wire logic              i_hw_permit_pin,
   input  wire logic              i_standby,
   input  wire logic              i_flash_enable,
   input  wire logic              i_psel,
   input  wire logic              i_penable,
   input  wire logic              i_pwrite,
   input  wire logic [ADDR_W-1:0] i_paddr,
   input  wire logic [31:0]       i_pwdata,
   input  wire logic [3:0]        i_pstrb,
   output logic      [31:0]       o_prdata,
   output logic                   o_pready,
   output logic                   o_pslverr,
   output logic                   o_sw_permit,
   output logic                   o_prog_mode,
   output logic                   o_erase_mode,
   output logic                   o_prog_check_mode,
   output logic                   o_erase_check_mode,
   output logic                   o_prog_setup,
   output logic                   o_erase_setup,
   output fmcr_pkg::fmcr_mode_t   o_mode
);

   initial begin
      if (ADDR_W < 3 || ADDR_W > 32) begin
         $error("fmcr_top: ADDR_W must be 3 to 32");
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register state

   logic [7:0]           ctrl_q;
   logic [7:0]           ctrl_d;
   logic [7:0]           gated;
   logic [31:0]          rdata_q;
   logic [31:0]          rdata_d;
   logic                 ready_q;
   logic                 ready_d;
   logic                 err_q;
   logic                 err_d;
   fmcr_pkg::fmcr_mode_t mode_q;
   fmcr_pkg::fmcr_mode_t mode_d;
   logic                 setup;
   logic                 hit_ctrl;
   logic                 hit_obs;
   logic                 wr_ok;

   assign setup    = i_psel & ~i_penable;
   assign hit_ctrl = i_paddr == ADDR_W'(`FMCR_CTRL_OFFSET);
   assign hit_obs  = i_paddr == ADDR_W'(`FMCR_OBS_OFFSET);
   // byte lane 0 carries the register
   assign wr_ok    = setup & i_pwrite & hit_ctrl & i_pstrb[0]
                     & i_flash_enable;

   fmcr_write_gate #(
      .WIDTH (8)
   ) u_gate (
      .i_cur       (ctrl_q),
      .i_wdata     (i_pwdata[7:0]),
      .i_hw_permit (i_hw_permit_pin),
      .o_next      (gated)
   );

   always_comb begin
      ctrl_d = ctrl_q;
      if (i_standby || !i_hw_permit_pin) begin
         // writable bits cleared; bit 7 comes from the pin
         ctrl_d = 8'h00;
      end else if (wr_ok) begin
         ctrl_d = gated;
      end
      ctrl_d[`FMCR_BIT_HW_PERMIT] = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // apb answer: no wait state, answer registered

   always_comb begin
      ready_d = 1'b0;
      err_d   = 1'b0;
      rdata_d = 32'h0000_0000;
      if (setup) begin
         ready_d = 1'b1;
         err_d   = ~(hit_ctrl | hit_obs)
                   | (i_pwrite & hit_obs);
         if (!i_pwrite && i_flash_enable) begin
            if (hit_ctrl) begin
               // live pin, so the first read after reset is right
               rdata_d[7:0] = {i_hw_permit_pin, ctrl_q[6:0]};
            end else if (hit_obs) begin
               rdata_d[2:0] = mode_q;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // selected array mode, decoded from the live bits

   always_comb begin
      mode_d = fmcr_pkg::FMCR_MODE_READ;
      if (ctrl_d[`FMCR_BIT_PROG]) begin
         mode_d = fmcr_pkg::FMCR_MODE_PROG;
      end else if (ctrl_d[`FMCR_BIT_ERASE]) begin
         mode_d = fmcr_pkg::FMCR_MODE_ERASE;
      end else if (ctrl_d[`FMCR_BIT_PROG_CHECK]) begin
         mode_d = fmcr_pkg::FMCR_MODE_PROG_CHECK;
      end else if (ctrl_d[`FMCR_BIT_ERASE_CHECK]) begin
         mode_d = fmcr_pkg::FMCR_MODE_ERASE_CHECK;
      end else if (ctrl_d[`FMCR_BIT_PROG_SETUP]) begin
         mode_d = fmcr_pkg::FMCR_MODE_PROG_SETUP;
      end else if (ctrl_d[`FMCR_BIT_ERASE_SETUP]) begin
         mode_d = fmcr_pkg::FMCR_MODE_ERASE_SETUP;
      end else if (ctrl_d[`FMCR_BIT_SW_PERMIT]) begin
         mode_d = fmcr_pkg::FMCR_MODE_PERMIT;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl_q  <= 8'h00;
         mode_q  <= fmcr_pkg::FMCR_MODE_READ;
         rdata_q <= 32'h0000_0000;
         ready_q <= 1'b0;
         err_q   <= 1'b0;
      end else begin
         ctrl_q  <= ctrl_d;
         mode_q  <= mode_d;
         rdata_q <= rdata_d;
         ready_q <= ready_d;
         err_q   <= err_d;
      end
   end

   assign o_prdata           = rdata_q;
   assign o_pready           = ready_q;
   assign o_pslverr          = err_q;
   assign o_sw_permit        = ctrl_q[`FMCR_BIT_SW_PERMIT];
   assign o_prog_mode        = ctrl_q[`FMCR_BIT_PROG];
   assign o_erase_mode       = ctrl_q[`FMCR_BIT_ERASE];
   assign o_prog_check_mode  = ctrl_q[`FMCR_BIT_PROG_CHECK];
   assign o_erase_check_mode = ctrl_q[`FMCR_BIT_ERASE_CHECK];
   assign o_prog_setup       = ctrl_q[`FMCR_BIT_PROG_SETUP];
   assign o_erase_setup      = ctrl_q[`FMCR_BIT_ERASE_SETUP];
   assign o_mode             = mode_q;

endmodule // fmcr_top

// ### tb/fmcr_properties.sv
// checker of the flash mode control register ports
module fmcr_properties (
   input logic        i_ref_clk,
   input logic        i_rst_b,
   input logic        i_hw_permit_pin,
   input logic        i_standby,
   input logic        i_flash_enable,
   input logic        i_psel,
   input logic        i_penable,
   input logic        i_pwrite,
   input logic [31:0] o_prdata,
   input logic        o_pready,
   input logic        o_pslverr,
   input logic        o_sw_permit,
   input logic        o_prog_mode,
   input logic        o_erase_mode,
   input logic        o_prog_check_mode,
   input logic        o_erase_check_mode,
   input logic        o_prog_setup,
   input logic        o_erase_setup
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);
   ready_after_setup_a: assert property (
      i_psel && !i_penable |=> o_pready) else $error("no ready");
   sw_permit_gate_a: assert property (
      $rose(o_sw_permit) |-> $past(i_hw_permit_pin && i_psel && i_pwrite))
      else $error("permit set without pin");
   setup_gate_a: assert property (
      $rose(o_prog_setup) || $rose(o_erase_setup) || $rose(o_prog_check_mode)
      || $rose(o_erase_check_mode)
      |-> $past(o_sw_permit)) else $error("setup without permit");
   erase_gate_a: assert property (
      $rose(o_erase_mode) |-> $past(o_erase_setup && o_sw_permit))
      else $error("erase without setup");
   prog_gate_a: assert property (
      $rose(o_prog_mode) |-> $past(o_prog_setup && o_sw_permit))
      else $error("program without setup");
   standby_clear_a: assert property (
      i_standby |=> !(o_sw_permit || o_prog_mode || o_erase_mode ||
      o_prog_setup || o_erase_setup)) else $error("standby kept bits");
   pin_low_clear_a: assert property (
      !i_hw_permit_pin [*2] |=> !o_sw_permit) else $error("pin low kept");
   disabled_read_a: assert property (
      o_pready && $past(!i_flash_enable && !i_pwrite) |-> o_prdata == 32'h0)
      else $error("disabled read not zero");
   cover property ($rose(o_prog_mode));
   cover property ($rose(o_erase_mode));
   cover property (o_pslverr);
endmodule // fmcr_properties

bind fmcr_top fmcr_properties u_fmcr_properties (.i_ref_clk(i_ref_clk),
   .i_rst_b(i_rst_b), .i_hw_permit_pin(i_hw_permit_pin),
   .i_standby(i_standby), .i_flash_enable(i_flash_enable), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .o_sw_permit(o_sw_permit),
   .o_prog_mode(o_prog_mode), .o_erase_mode(o_erase_mode),
   .o_prog_check_mode(o_prog_check_mode),
   .o_erase_check_mode(o_erase_check_mode), .o_prog_setup(o_prog_setup),
   .o_erase_setup(o_erase_setup));

// ### tb/fmcr_tb_top.sv
// self-checking bench of the flash mode control register
`include "fmcr_defines.svh"
module fmcr_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic                 clk = 0, rst_b = 0, pin = 1, stby = 0, fen = 1;
   logic                 psel = 0, pen = 0, pwr = 0, ready, err, rerr;
   logic [11:0]          addr = 0;
   logic [31:0]          wd = 0, rd, prdata;
   fmcr_pkg::fmcr_mode_t mode;
   int                   errors = 0, tests_run = 0;
   // write value, mode, control read back
   logic [19:0] t [13] = '{20'h01080, 20'h20080, 20'h407c0, 20'h427c0,
      20'h503d0, 20'h514d1, 20'h503d0, 20'h605e0, 20'h626e2, 20'h605e0,
      20'h441c4, 20'h482c8, 20'h407c0};
   always #20 clk = ~clk;
   fmcr_top u_fmcr_top (.i_ref_clk(clk), .i_rst_b(rst_b),
      .i_hw_permit_pin(pin), .i_standby(stby), .i_flash_enable(fen),
      .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(addr),
      .i_pwdata(wd), .i_pstrb(4'h1), .o_prdata(prdata), .o_pready(ready),
      .o_pslverr(err), .o_sw_permit(), .o_prog_mode(), .o_erase_mode(),
      .o_prog_check_mode(), .o_erase_check_mode(), .o_prog_setup(),
      .o_erase_setup(), .o_mode(mode));
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwr <= w;
      addr <= a;
      wd <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (ready !== 1'b1 && n < 9);
      rd = prdata;
      rerr = err;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic chk(input string s, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h seen %h", s, exp, seen);
      end
   endtask
   task automatic rdc(input logic [31:0] exp);
      apb(1'b0, `FMCR_CTRL_OFFSET, 32'h0);
      chk("ctrl", rd, exp);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      errors++;
      give_verdict();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rdc(32'h80);
      foreach (t[i]) begin
         apb(1'b1, `FMCR_CTRL_OFFSET, {24'h0, t[i][19:12]});
         rdc({24'h0, t[i][7:0]});
         chk("mode", {29'h0, mode}, {29'h0, t[i][10:8]});
      end
      $display("test sequences done");
      fen <= 1'b0;
      rdc(32'h0);
      apb(1'b1, `FMCR_CTRL_OFFSET, 32'h0);
      fen <= 1'b1;
      rdc(32'hc0);
      apb(1'b0, 12'h008, 32'h0);
      chk("slverr", {31'h0, rerr}, 32'h1);
      $display("test disable done");
      apb(1'b1, `FMCR_CTRL_OFFSET, 32'h0);
      rdc(32'h80);
      stby <= 1'b1;
      repeat (2) @(posedge clk);
      stby <= 1'b0;
      rdc(32'h80);
      apb(1'b1, `FMCR_CTRL_OFFSET, 32'h40);
      pin <= 1'b0;
      repeat (3) @(posedge clk);
      rdc(32'h0);
      apb(1'b1, `FMCR_CTRL_OFFSET, 32'h40);
      rdc(32'h0);
      pin <= 1'b1;
      repeat (2) @(posedge clk);
      rdc(32'h80);
      $display("test protect done");
      give_verdict();
   end
endmodule // fmcr_tb_top
